// File: logic/owfs_sequencer.v
// measurement sequencer: warm-up, fake measurements, auto offset, result path
// Functional notes
// - with subtract-enable set, compute offset after init and subtract from results
// - offset averages 2^n measurements, n from 3-bit field
// - single mode with subtraction raises no interrupt per offset measurement
// - warm-up dummies run only after init command or reset
// - warm-up code 0 none, 1 gives 16, doubling to 1024 at 7
// - both arithmetic units reset to speed setting 1
// - after reset run fake measurements without post-processing
// - both units contending for ram sets processing-error flag bit 19
// - fake field codes 0..3 insert 0, 1, 2, 4 measurements
// - single mode stops after each measurement until next start
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "owfs_defines.vh"
module owfs_sequencer (
    input  wire        clock_i,
    input  wire        rst_i,
    input  wire [3:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    input  wire [23:0] raw_result_i,
    output reg  [31:0] rdata_o,
    output reg  [23:0] result_o,
    output reg         result_valid_o,
    output reg         irq_o
);
    localparam ST_IDLE  = 3'd0;
    localparam ST_WARM  = 3'd1;
    localparam ST_FAKE  = 3'd2;
    localparam ST_OFS   = 3'd3;
    localparam ST_RUN   = 3'd4;
    localparam ST_WAIT  = 3'd5;

    ////////////////////////////////////////////////////////////////////////
    reg [7:0]  cfg0_r;
    reg [11:0] cfg2_r;
    reg [2:0]  state_r;
    reg [2:0]  ret_r;
    reg [15:0] cyc_r;
    reg [10:0] cnt_r;
    reg [31:0] acc_r;
    reg [23:0] offset_r;
    reg        ofs_valid_r;
    reg        err_dsp_r;
    reg [1:0]  irq_stat_r;
    reg [1:0]  irq_mask_r;
    reg        start_pend_r;
    reg        meas_end_r;
    reg        post_r;
    reg        meas_ofs_r;

    wire       init_cmd  = wr_i && addr_i == `OWFS_ADDR_CTRL && wdata_i[`OWFS_CTRL_INIT];
    wire       start_cmd = wr_i && addr_i == `OWFS_ADDR_CTRL && wdata_i[`OWFS_CTRL_START];
    wire       single    = cfg0_r[`OWFS_CFG0_SINGLE];
    wire       sub_ofs   = cfg0_r[`OWFS_CFG0_SUBOFS];
    wire [2:0] wu_code   = cfg0_r[`OWFS_CFG0_WU_HI:`OWFS_CFG0_WU_LO];
    wire [2:0] avg_code  = cfg2_r[`OWFS_CFG2_AVG_HI:`OWFS_CFG2_AVG_LO];
    wire [1:0] fake_code = cfg2_r[`OWFS_CFG2_FAKE_HI:`OWFS_CFG2_FAKE_LO];
    wire [10:0] wu_num   = (wu_code == 3'd0) ? 11'd0 : (11'd8 << wu_code);
    wire [10:0] fake_num = (fake_code == 2'd3) ? 11'd4 : {9'd0, fake_code};
    wire [10:0] avg_num  = 11'd1 << avg_code;
    wire       cyc_end   = cyc_r == 16'h0000;
    wire [31:0] ofs_sum  = acc_r + {8'h0, raw_result_i};
    wire [31:0] ofs_mean = ofs_sum >> avg_code;
    // offset runs are tagged when they end; state has moved on by the time results leave
    wire       real_done = meas_end_r && !meas_ofs_r;
    wire       au1_req;
    wire       au2_req;

    ////////////////////////////////////////////////////////////////////////
    // both units read and write the same ram when they finish
    owfs_arith_unit u_au1 (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .start_i   (meas_end_r & post_r),
        .speed_i   (cfg2_r[`OWFS_CFG2_SPD1_LO+1:`OWFS_CFG2_SPD1_LO]),
        .ram_req_o (au1_req),
        .done_o    ()
    );
    owfs_arith_unit u_au2 (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .start_i   (meas_end_r & post_r),
        .speed_i   (cfg2_r[`OWFS_CFG2_SPD2_LO+1:`OWFS_CFG2_SPD2_LO]),
        .ram_req_o (au2_req),
        .done_o    ()
    );

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock_i) begin
        if (rst_i) begin
            cfg0_r     <= `OWFS_CFG0_RST;
            cfg2_r     <= `OWFS_CFG2_RST;
            irq_mask_r <= 2'h0;
        end else if (wr_i) begin
            case (addr_i)
                `OWFS_ADDR_CFG0:     cfg0_r     <= wdata_i[7:0];
                `OWFS_ADDR_CFG2:     cfg2_r     <= wdata_i[11:0];
                `OWFS_ADDR_IRQ_MASK: irq_mask_r <= wdata_i[1:0];
                default:             cfg0_r     <= cfg0_r;
            endcase
        end
    end

    always @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0;
        end else if (rd_i) begin
            case (addr_i)
                `OWFS_ADDR_CFG0:     rdata_o <= {24'h0, cfg0_r};
                `OWFS_ADDR_CFG2:     rdata_o <= {20'h0, cfg2_r};
                `OWFS_ADDR_STAT:     rdata_o <= {12'h0, err_dsp_r, 7'h0, ofs_valid_r, 8'h0, state_r};
                `OWFS_ADDR_IRQ_STAT: rdata_o <= {30'h0, irq_stat_r};
                `OWFS_ADDR_IRQ_MASK: rdata_o <= {30'h0, irq_mask_r};
                `OWFS_ADDR_OFFSET:   rdata_o <= {8'h0, offset_r};
                default:             rdata_o <= 32'h0;
            endcase
        end else begin
            rdata_o <= 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer; one measurement lasts a fixed number of clocks
    always @(posedge clock_i) begin
        if (rst_i) begin
            state_r      <= ST_WARM;
            ret_r        <= ST_IDLE;
            cyc_r        <= `OWFS_MEAS_CYCLES;
            cnt_r        <= 11'd0;
            acc_r        <= 32'h0;
            offset_r     <= 24'h0;
            ofs_valid_r  <= 1'b0;
            start_pend_r <= 1'b0;
            meas_end_r   <= 1'b0;
            post_r       <= 1'b0;
            meas_ofs_r   <= 1'b0;
        end else begin
            meas_end_r <= 1'b0;
            if (start_cmd)
                start_pend_r <= 1'b1;
            if (init_cmd) begin
                state_r      <= ST_WARM;
                cyc_r        <= `OWFS_MEAS_CYCLES;
                cnt_r        <= 11'd0;
                acc_r        <= 32'h0;
                offset_r     <= 24'h0;
                ofs_valid_r  <= 1'b0;
                start_pend_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_WARM: begin
                        if (cnt_r >= wu_num) begin
                            state_r <= ST_FAKE;
                            cnt_r   <= 11'd0;
                        end else if (cyc_end) begin
                            cnt_r <= cnt_r + 11'd1;
                            cyc_r <= `OWFS_MEAS_CYCLES;
                        end else begin
                            cyc_r <= cyc_r - 16'h0001;
                        end
                    end
                    ST_FAKE: begin
                        if (cnt_r >= fake_num) begin
                            state_r <= sub_ofs ? ST_OFS : ST_RUN;
                            cnt_r   <= 11'd0;
                            acc_r   <= 32'h0;
                        end else if (cyc_end) begin
                            cnt_r <= cnt_r + 11'd1;
                            cyc_r <= `OWFS_MEAS_CYCLES;
                        end else begin
                            cyc_r <= cyc_r - 16'h0001;
                        end
                    end
                    ST_OFS, ST_RUN: begin
                        if (single && !start_pend_r) begin
                            cyc_r <= `OWFS_MEAS_CYCLES;
                        end else if (cyc_end) begin
                            cyc_r        <= `OWFS_MEAS_CYCLES;
                            start_pend_r <= 1'b0;
                            meas_end_r   <= 1'b1;
                            post_r       <= 1'b1;
                            meas_ofs_r   <= state_r == ST_OFS;
                            if (state_r == ST_OFS) begin
                                acc_r <= ofs_sum;
                                cnt_r <= cnt_r + 11'd1;
                                if (cnt_r + 11'd1 == avg_num) begin
                                    offset_r    <= ofs_mean[23:0];
                                    ofs_valid_r <= 1'b1;
                                    state_r     <= ST_RUN;
                                end
                            end
                            if (single) begin
                                ret_r   <= (state_r == ST_OFS && cnt_r + 11'd1 != avg_num) ? ST_OFS : ST_RUN;
                                state_r <= ST_WAIT;
                            end
                        end else begin
                            cyc_r <= cyc_r - 16'h0001;
                        end
                    end
                    ST_WAIT: begin
                        state_r <= ret_r;
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result output; offset measurements load result_o but give no valid pulse and no interrupt
    always @(posedge clock_i) begin
        if (rst_i) begin
            result_o       <= 24'h0;
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= real_done;
            if (meas_end_r)
                result_o <= ofs_valid_r && sub_ofs ? raw_result_i - offset_r : raw_result_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // set wins over write-one-clear
    always @(posedge clock_i) begin
        if (rst_i) begin
            err_dsp_r  <= 1'b0;
            irq_stat_r <= 2'h0;
            irq_o      <= 1'b0;
        end else begin
            if (au1_req && au2_req)
                err_dsp_r <= 1'b1;
            else if (init_cmd)
                err_dsp_r <= 1'b0;
            irq_stat_r[`OWFS_IRQ_DONE] <= real_done
                || (irq_stat_r[`OWFS_IRQ_DONE]
                && !(wr_i && addr_i == `OWFS_ADDR_IRQ_STAT && wdata_i[`OWFS_IRQ_DONE]));
            irq_stat_r[`OWFS_IRQ_ERR] <= (au1_req && au2_req)
                || (irq_stat_r[`OWFS_IRQ_ERR]
                && !(wr_i && addr_i == `OWFS_ADDR_IRQ_STAT && wdata_i[`OWFS_IRQ_ERR]));
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end
endmodule // owfs_sequencer

// File: logic/owfs_defines.vh
// constants for the offset, warm-up and fake-measurement sequencer
`ifndef OWFS_DEFINES_VH
`define OWFS_DEFINES_VH

`define OWFS_ADDR_CFG0      4'h0
`define OWFS_ADDR_CFG2      4'h2
`define OWFS_ADDR_CTRL      4'h4
`define OWFS_ADDR_STAT      4'h5
`define OWFS_ADDR_IRQ_STAT  4'h6
`define OWFS_ADDR_IRQ_MASK  4'h7
`define OWFS_ADDR_OFFSET    4'h8

`define OWFS_CFG0_SUBOFS    7
`define OWFS_CFG0_SINGLE    6
`define OWFS_CFG0_DOUBLE    5
`define OWFS_CFG0_WU_LO     0
`define OWFS_CFG0_WU_HI     2
`define OWFS_CFG2_AVG_LO    4
`define OWFS_CFG2_AVG_HI    6
`define OWFS_CFG2_FAKE_LO   0
`define OWFS_CFG2_FAKE_HI   1
`define OWFS_CFG2_SPD1_LO   8
`define OWFS_CFG2_SPD2_LO   10

`define OWFS_STAT_ERR_DSP   19

`define OWFS_CFG0_RST       8'h00
`define OWFS_CFG2_RST       12'h500

`define OWFS_CTRL_INIT      0
`define OWFS_CTRL_START     1

`define OWFS_IRQ_DONE       0
`define OWFS_IRQ_ERR        1

`define OWFS_MEAS_CYCLES    16'h0040
`endif

// File: logic/owfs_arith_unit.v
// one arithmetic unit: busy for a speed-dependent time, then claims the shared ram
`timescale 1ns/1ps
module owfs_arith_unit (
    input  wire        clock_i,
    input  wire        rst_i,
    input  wire        start_i,
    input  wire [1:0]  speed_i,
    output reg         ram_req_o,
    output reg         done_o
);
    reg [7:0] cnt_r;
    reg       busy_r;
    // higher speed settings only stretch the run time
    wire [7:0] run_len = 8'h10 + {4'h0, speed_i, 2'h0};

    always @(posedge clock_i) begin
        if (rst_i) begin
            cnt_r     <= 8'h00;
            busy_r    <= 1'b0;
            ram_req_o <= 1'b0;
            done_o    <= 1'b0;
        end else begin
            done_o    <= 1'b0;
            ram_req_o <= 1'b0;
            if (start_i) begin
                busy_r <= 1'b1;
                cnt_r  <= run_len;
            end else if (busy_r) begin
                if (cnt_r == 8'h00) begin
                    busy_r    <= 1'b0;
                    done_o    <= 1'b1;
                    ram_req_o <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 8'h01;
                end
            end
        end
    end
endmodule // owfs_arith_unit

// File: bench/owfs_sensor_model.sv
// bridge front-end stand-in: raw measurement value seen by the sequencer
`timescale 1ns/1ps
module owfs_sensor_model #(
    parameter logic [23:0] BASE = 24'h012340
) (
    input  logic        clock_i,
    input  logic [23:0] load_i,
    output logic [23:0] raw_o
);
    // no-load value plus applied load, updated every clock like a live bridge
    always_ff @(posedge clock_i) begin
        raw_o <= BASE + load_i;
    end
endmodule // owfs_sensor_model

// File: bench/owfs_sequencer_properties.sv
// port checker for the measurement sequencer
`timescale 1ns/1ps
module owfs_sequencer_checker (
    input logic        clock_i,
    input logic        rst_i,
    input logic [3:0]  addr_i,
    input logic [31:0] wdata_i,
    input logic        wr_i,
    input logic        rd_i,
    input logic [23:0] raw_result_i,
    input logic [31:0] rdata_o,
    input logic [23:0] result_o,
    input logic        result_valid_o,
    input logic        irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    int         cnt_r;
    logic       start_r;
    logic       single_r;
    logic [1:0] mask_r;
    wire        init_w  = wr_i && addr_i == 4'h4 && wdata_i[0];
    wire        start_w = wr_i && addr_i == 4'h4 && wdata_i[1];
    ////////////////////////////////////////////////////////////////////////////////
    // shadows of what software wrote; cnt_r saturates so it never wraps
    always_ff @(posedge clock_i) begin
        if (rst_i || init_w) begin
            cnt_r   <= 0;
            start_r <= 1'b0;
        end else begin
            cnt_r   <= (cnt_r < 1000) ? cnt_r + 1 : cnt_r;
            start_r <= start_w ? 1'b1 : (result_valid_o ? 1'b0 : start_r);
        end
        if (rst_i) begin
            single_r <= 1'b0;
            mask_r   <= 2'h0;
        end else begin
            single_r <= (wr_i && addr_i == 4'h0) ? wdata_i[6] : single_r;
            mask_r   <= (wr_i && addr_i == 4'h7) ? wdata_i[1:0] : mask_r;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_cfg2_reset: assert property (disable iff (rst_i)
        $past(rst_i) && rd_i && addr_i == 4'h2 |=> rdata_o[11:8] == 4'h5) else $error("speed reset wrong");
    a_rst_quiet: assert property (
        rst_i |=> rdata_o == 32'h0 && !result_valid_o && !irq_o) else $error("outputs active in reset");
    a_first_result: assert property (disable iff (rst_i)
        result_valid_o |-> cnt_r >= 63) else $error("result too soon after restart");
    a_start_needed: assert property (disable iff (rst_i)
        result_valid_o && single_r |-> start_r) else $error("single mode result without start");
    a_valid_pulse: assert property (disable iff (rst_i)
        result_valid_o |=> !result_valid_o) else $error("result valid too long");
    a_cfg0_readback: assert property (disable iff (rst_i)
        wr_i && addr_i == 4'h0 ##1 !wr_i ##1 rd_i && addr_i == 4'h0 |=> rdata_o[7:0] == $past(wdata_i[7:0], 3))
        else $error("cfg0 readback wrong");
    a_irq_masked: assert property (disable iff (rst_i)
        irq_o |-> $past(mask_r) != 2'h0) else $error("irq with all masked");
    a_irq_done: assert property (disable iff (rst_i)
        result_valid_o && mask_r[0] |-> ##[0:3] irq_o) else $error("done irq missing");
    a_rdata_idle: assert property (disable iff (rst_i)
        !$past(rd_i) |-> rdata_o == 32'h0) else $error("read data outside answer cycle");
endmodule // owfs_sequencer_checker
bind owfs_sequencer owfs_sequencer_checker owfs_sequencer_checker_inst (.clock_i(clock_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .raw_result_i(raw_result_i),
    .rdata_o(rdata_o), .result_o(result_o), .result_valid_o(result_valid_o), .irq_o(irq_o));

// File: bench/tb_top.sv
// register-level testbench of the measurement sequencer
`timescale 1ns/1ps
module tb_top;
    localparam logic [23:0] BASE = 24'h012340;
    logic        clock_i = 1'b0;
    logic        rst_i   = 1'b1;
    logic [3:0]  addr_i  = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i    = 1'b0;
    logic        rd_i    = 1'b0;
    logic [23:0] load    = 24'h0;
    logic [31:0] d;
    wire  [23:0] raw;
    wire  [23:0] result;
    wire  [31:0] rdata;
    wire         valid;
    wire         irq;
    int          num_errors = 0;
    int          checked = 0;
    int          nvalid = 0;
    int          nv0;
    int          n0;
    int          n;
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) if (valid === 1'b1) nvalid <= nvalid + 1;
    owfs_sensor_model #(.BASE(BASE)) owfs_sensor_model_inst (.clock_i(clock_i), .load_i(load), .raw_o(raw));
    owfs_sequencer owfs_sequencer_inst (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .raw_result_i(raw), .rdata_o(rdata), .result_o(result),
        .result_valid_o(valid), .irq_o(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // tasks start in the time step of a rising edge; an idle edge follows each strobe
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clock_i);
        wr_i <= 1'b0;
        @(posedge clock_i);
    endtask
    // read data stand only in the cycle after the strobe; taken at its closing edge
    task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(posedge clock_i);
        d = rdata;
        chk(nm, e, d & m);
    endtask
    task automatic wv(output int c);
        c = 0;
        do begin
            @(posedge clock_i);
            c++;
        end while (valid !== 1'b1 && c < 20000);
        if (c >= 20000) num_errors++;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        rdc("cfg2 reset", 4'h2, 32'hfff, 32'h500);
        rdc("cfg0 reset", 4'h0, 32'hff, 32'h0);
        rdc("unmapped", 4'hf, 32'hffffffff, 32'h0);
        wr(4'h2, 32'h900);
        wr(4'h0, 32'h87);
        rdc("cfg0 back", 4'h0, 32'hff, 32'h87);
        wr(4'h0, 32'h0);
        wr(4'h4, 32'h1);
        wv(n0);
        load <= 24'h123;
        wv(n);
        wv(n);
        chk("plain result", BASE + 24'h123, result);
        wr(4'h0, 32'h1);
        wr(4'h4, 32'h1);
        wv(n);
        chk("warm-up delay", 1, n >= n0 + 16 * 64);
        wv(n);
        chk("no repeat warm-up", 1, n < 100);
        wr(4'h0, 32'h0);
        wr(4'h2, 32'h903);
        wr(4'h4, 32'h1);
        wv(n);
        chk("fake delay", 1, n >= n0 + 4 * 64);
        load <= 24'h0;
        wr(4'h2, 32'h920);
        wr(4'h0, 32'h80);
        wr(4'h4, 32'h1);
        wv(n);
        chk("offset delay", 1, n >= n0 + 4 * 64);
        rdc("offset valid", 4'h5, 32'h800, 32'h800);
        rdc("offset", 4'h8, 32'hffffff, BASE);
        load <= 24'h55;
        wv(n);
        wv(n);
        chk("subtracted", 24'h55, result);
        rdc("offset held", 4'h8, 32'hffffff, BASE);
        // single mode with subtraction; offset averages two measurements, each needing a start
        wr(4'h6, 32'h1);
        wr(4'h7, 32'h1);
        wr(4'h2, 32'h910);
        wr(4'h0, 32'hc0);
        nv0 = nvalid;
        wr(4'h4, 32'h1);
        for (int i = 0; i < 2; i++) begin
            wr(4'h4, 32'h2);
            repeat (200) @(posedge clock_i);
        end
        chk("offset pulses", nv0, nvalid);
        rdc("offset irq", 4'h6, 32'h1, 32'h0);
        wr(4'h4, 32'h2);
        wv(n);
        repeat (2) @(posedge clock_i);
        chk("done irq", 1, irq);
        rdc("done status", 4'h6, 32'h1, 32'h1);
        wr(4'h6, 32'h1);
        repeat (2) @(posedge clock_i);
        chk("irq cleared", 0, irq);
        nv0 = nvalid;
        repeat (300) @(posedge clock_i);
        chk("single stops", nv0, nvalid);
        // equal speeds make both units claim the ram together
        wr(4'h7, 32'h2);
        wr(4'h0, 32'h0);
        wr(4'h2, 32'h500);
        wr(4'h4, 32'h1);
        wv(n);
        wv(n);
        rdc("dsp error", 4'h5, 32'h80000, 32'h80000);
        repeat (2) @(posedge clock_i);
        chk("error irq", 1, irq);
        wr(4'h4, 32'h1);
        rdc("error cleared", 4'h5, 32'h80000, 32'h0);
        wr(4'h6, 32'h2);
        wr(4'h7, 32'h0);
        finish_test;
    end
    initial begin
        #200000;
        num_errors++;
        finish_test;
    end
endmodule // tb_top
